// *** frsp_pkg.sv ***
// Constants, types and shared layouts of the flash row self-programming sequencer.
// Assumes one clock domain; used by frsp_top and its two leaf modules.
package frsp_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned LATCH_COUNT = 32;
   localparam int unsigned LATCH_SEL_W = 5;
   localparam int unsigned ROW_W       = 10;
   localparam int unsigned WORD_W      = 14;
   localparam logic [13:0] BLANK_WORD  = 14'h3fff;
   localparam int unsigned ROW_SEL_LO  = 5;
   localparam int unsigned ROW_SEL_HI  = 7;

   // ---------------------------------------------------------------
   // Unlock keys
   // ---------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned OP_TIME_NS    = 200;
   localparam int unsigned OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OP_CNT_W      = 8;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FRSP_IDLE  = 2'b00,
      FRSP_KEY1  = 2'b01,
      FRSP_ARMED = 2'b11
   } frsp_unlock_t;

   typedef enum logic [1:0] {
      FRSP_OP_IDLE  = 2'b00,
      FRSP_OP_PROG  = 2'b01,
      FRSP_OP_ERASE = 2'b11
   } frsp_op_t;

   typedef struct packed {
      logic                     load;
      logic [LATCH_SEL_W-1:0]   sel;
      logic [WORD_W-1:0]        word;
      logic                     blank;
   } frsp_latch_cmd_t;

   typedef struct packed {
      logic              prog;
      logic              erase;
      logic [ROW_W-1:0]  row;
   } frsp_array_req_t;

endpackage : frsp_pkg

// *** frsp_latches.sv ***
// Row of 32 write latches, blank on reset and on every clear.
// Assumes commands come from logic on the same clock.
`timescale 1ns/1ps
module frsp_latches (
   input  wire logic                                      clk_sys_in,
   input  wire logic                                      nrst_in,
   input  wire frsp_pkg::frsp_latch_cmd_t                 cmd_in,
   output logic [frsp_pkg::LATCH_COUNT*frsp_pkg::WORD_W-1:0] row_out
);
   typedef struct packed {
      logic [frsp_pkg::LATCH_COUNT-1:0][frsp_pkg::WORD_W-1:0] lat;
   } frsp_lat_state_t;

   frsp_lat_state_t s_q;
   frsp_lat_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (cmd_in.blank) begin
         for (int i = 0; i < frsp_pkg::LATCH_COUNT; i++) begin
            s_d.lat[i] = frsp_pkg::BLANK_WORD;
         end
      end else if (cmd_in.load) begin
         s_d.lat[cmd_in.sel] = cmd_in.word;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= {frsp_pkg::LATCH_COUNT{frsp_pkg::BLANK_WORD}};
      end else begin
         s_q <= s_d;
      end
   end

   assign row_out = s_q.lat;
endmodule : frsp_latches

// *** frsp_timer.sv ***
// Fixed-length busy timer for one array operation.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module frsp_timer (
   input  wire logic clk_sys_in,
   input  wire logic nrst_in,
   input  wire logic start_in,
   output logic      done_out
);
   typedef struct packed {
      logic [frsp_pkg::OP_CNT_W-1:0] cnt;
      logic                          run;
      logic                          done;
   } frsp_tmr_state_t;

   frsp_tmr_state_t s_q;
   frsp_tmr_state_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start_in) begin
         s_d.run = 1'b1;
         s_d.cnt = frsp_pkg::OP_CNT_W'(frsp_pkg::OP_CYCLES - 1);
      end else if (s_q.run) begin
         if (s_q.cnt == '0) begin
            s_d.run  = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done_out = s_q.done;
endmodule : frsp_timer

// *** frsp_top.sv ***
// Flash row self-programming sequencer: address, data and control bits as
// plain ports, unlock check, latch row, array request and CPU stall.
// Assumes register writes are one-cycle strobes from the CPU on clk_sys_in;
// the array answers with a fixed-length busy period.
`timescale 1ns/1ps
module frsp_top (
   input  wire logic                                         clk_sys_in,
   input  wire logic                                         nrst_in,
   input  wire logic                                         addr_high_wr_in,
   input  wire logic                                         addr_low_wr_in,
   input  wire logic                                         word_high_wr_in,
   input  wire logic                                         word_low_wr_in,
   input  wire logic                                         unlock_key_wr_in,
   input  wire logic                                         start_set_in,
   input  wire logic                                         ctrl_wr_in,
   input  wire logic [7:0]                                   wdata_in,
   input  wire logic                                         write_enable_bit_in,
   input  wire logic                                         erase_select_in,
   input  wire logic                                         latch_only_load_in,
   input  wire logic                                         config_space_select_in,
   input  wire logic                                         mem_op_irq_enable_in,
   input  wire logic                                         mem_op_irq_clear_in,
   input  wire logic                                         code_protect_in,
   input  wire logic                                         row_protect_in,
   output logic [6:0]                                        flash_addr_high_out,
   output logic [7:0]                                        flash_addr_low_out,
   output logic [5:0]                                        flash_word_high_out,
   output logic [7:0]                                        flash_word_low_out,
   output logic                                              write_start_out,
   output logic                                              cpu_stall_out,
   output logic                                              mem_op_irq_flag_out,
   output logic                                              mem_op_irq_out,
   output logic                                              array_prog_out,
   output logic                                              array_erase_out,
   output logic [frsp_pkg::ROW_W-1:0]                        array_row_out,
   output logic [frsp_pkg::LATCH_COUNT*frsp_pkg::WORD_W-1:0] array_data_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [6:0]                 addr_high;
      logic [7:0]                 addr_low;
      logic [5:0]                 word_high;
      logic [7:0]                 word_low;
      frsp_pkg::frsp_unlock_t     unlock;
      frsp_pkg::frsp_op_t         op;
      logic                       start;
      logic                       stall;
      logic                       irq_flag;
      logic                       irq;
      frsp_pkg::frsp_array_req_t  req;
      frsp_pkg::frsp_latch_cmd_t  lcmd;
      logic                       tmr_go;
   } frsp_state_t;

   frsp_state_t s_q;
   frsp_state_t s_d;
   logic        op_done;
   logic [frsp_pkg::ROW_W-1:0] row_sel;

   // Row from high 6:0 and low 7:5; latch index never touches it
   assign row_sel = {s_q.addr_high,
                     s_q.addr_low[frsp_pkg::ROW_SEL_HI:frsp_pkg::ROW_SEL_LO]};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d        = s_q;
      s_d.lcmd   = '0;
      s_d.tmr_go = 1'b0;

      // Register loads are refused while an operation runs
      if (s_q.op == frsp_pkg::FRSP_OP_IDLE) begin
         if (addr_high_wr_in) s_d.addr_high = wdata_in[6:0];
         if (addr_low_wr_in)  s_d.addr_low  = wdata_in;
         if (word_high_wr_in) s_d.word_high = wdata_in[5:0];
         if (word_low_wr_in)  s_d.word_low  = wdata_in;
      end

      // Unlock tracker: a wrong key, a control write or a start write breaks the key sequence; address and word writes do not
      unique case (s_q.unlock)
         frsp_pkg::FRSP_IDLE: begin
            if (unlock_key_wr_in && wdata_in == frsp_pkg::KEY_FIRST) begin
               s_d.unlock = frsp_pkg::FRSP_KEY1;
            end
         end
         frsp_pkg::FRSP_KEY1: begin
            if (unlock_key_wr_in && wdata_in == frsp_pkg::KEY_SECOND) begin
               s_d.unlock = frsp_pkg::FRSP_ARMED;
            end else if (unlock_key_wr_in || ctrl_wr_in || start_set_in) begin
               s_d.unlock = frsp_pkg::FRSP_IDLE;
            end
         end
         frsp_pkg::FRSP_ARMED: begin
            if (start_set_in || unlock_key_wr_in || ctrl_wr_in) begin
               s_d.unlock = frsp_pkg::FRSP_IDLE;
            end
         end
         default: s_d.unlock = frsp_pkg::FRSP_IDLE;
      endcase

      // Start only after both keys with no key, control or start write between, with writes enabled
      if (start_set_in && s_q.unlock == frsp_pkg::FRSP_ARMED
          && write_enable_bit_in && !config_space_select_in
          && s_q.op == frsp_pkg::FRSP_OP_IDLE) begin
         if (code_protect_in) begin
            s_d.start = 1'b0;
         end else if (erase_select_in) begin
            if (row_protect_in) begin
               s_d.start = 1'b0;
            end else begin
               s_d.start     = 1'b1;
               s_d.stall     = 1'b1;
               s_d.op        = frsp_pkg::FRSP_OP_ERASE;
               s_d.req.erase = 1'b1;
               s_d.req.row   = row_sel;
               s_d.tmr_go    = 1'b1;
            end
         end else if (latch_only_load_in) begin
            s_d.lcmd.load = 1'b1;
            s_d.lcmd.sel  = s_q.addr_low[frsp_pkg::LATCH_SEL_W-1:0];
            s_d.lcmd.word = {s_q.word_high, s_q.word_low};
         end else begin
            // Whole latch row, no pre-erase
            s_d.lcmd.load = 1'b1;
            s_d.lcmd.sel  = s_q.addr_low[frsp_pkg::LATCH_SEL_W-1:0];
            s_d.lcmd.word = {s_q.word_high, s_q.word_low};
            s_d.start     = 1'b1;
            s_d.stall     = 1'b1;
            s_d.op        = frsp_pkg::FRSP_OP_PROG;
            s_d.req.prog  = 1'b1;
            s_d.req.row   = row_sel;
            s_d.tmr_go    = 1'b1;
         end
      end

      // Completion
      if (op_done && s_q.op != frsp_pkg::FRSP_OP_IDLE) begin
         s_d.start      = 1'b0;
         s_d.stall      = 1'b0;
         s_d.req.prog   = 1'b0;
         s_d.req.erase  = 1'b0;
         s_d.lcmd.blank = 1'b1;
         s_d.op         = frsp_pkg::FRSP_OP_IDLE;
         if (s_q.op == frsp_pkg::FRSP_OP_ERASE) begin
            s_d.irq_flag = 1'b1;
         end
      end else if (mem_op_irq_clear_in) begin
         s_d.irq_flag = 1'b0;
      end

      s_d.irq = s_d.irq_flag && mem_op_irq_enable_in;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Leaves
   // ---------------------------------------------------------------
   frsp_latches u_latches (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .cmd_in     (s_q.lcmd),
      .row_out    (array_data_out)
   );

   frsp_timer u_timer (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .start_in   (s_q.tmr_go),
      .done_out   (op_done)
   );

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign flash_addr_high_out = s_q.addr_high;
   assign flash_addr_low_out  = s_q.addr_low;
   assign flash_word_high_out = s_q.word_high;
   assign flash_word_low_out  = s_q.word_low;
   assign write_start_out     = s_q.start;
   assign cpu_stall_out       = s_q.stall;
   assign mem_op_irq_flag_out = s_q.irq_flag;
   assign mem_op_irq_out      = s_q.irq;
   assign array_prog_out      = s_q.req.prog;
   assign array_erase_out     = s_q.req.erase;
   assign array_row_out       = s_q.req.row;

endmodule : frsp_top

// *** frsp_top_properties.sv ***
// Port-level concurrent checks of the flash row sequencer.
// Assumes one clock domain; bound to frsp_top by the test bench.
`timescale 1ns/1ps
module frsp_top_properties (
   input wire logic         clk_sys_in,
   input wire logic         nrst_in,
   input wire logic         start_set_in,
   input wire logic         write_enable_bit_in,
   input wire logic         erase_select_in,
   input wire logic         latch_only_load_in,
   input wire logic         config_space_select_in,
   input wire logic         mem_op_irq_enable_in,
   input wire logic         code_protect_in,
   input wire logic         row_protect_in,
   input wire logic [6:0]   flash_addr_high_out,
   input wire logic [7:0]   flash_addr_low_out,
   input wire logic         write_start_out,
   input wire logic         cpu_stall_out,
   input wire logic         mem_op_irq_flag_out,
   input wire logic         mem_op_irq_out,
   input wire logic         array_prog_out,
   input wire logic         array_erase_out,
   input wire logic [9:0]   array_row_out,
   input wire logic [447:0] array_data_out
);
   localparam logic [447:0] BLANK = {frsp_pkg::LATCH_COUNT{frsp_pkg::BLANK_WORD}};
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);

   // ---------------------------------------------------------------
   // Operation start and shape
   // ---------------------------------------------------------------
   property p_start;
      $rose(write_start_out) |-> $past(start_set_in) && $past(write_enable_bit_in)
         && !$past(config_space_select_in) && !$past(code_protect_in);
   endproperty
   a_start: assert property (p_start) else $error("start without valid unlock");
   property p_stall;
      cpu_stall_out == write_start_out && write_start_out == (array_prog_out | array_erase_out);
   endproperty
   a_stall: assert property (p_stall) else $error("stall differs from operation");
   property p_one_kind;
      !(array_prog_out && array_erase_out);
   endproperty
   a_one_kind: assert property (p_one_kind) else $error("program and erase together");
   property p_prog_mode;
      $rose(array_prog_out) |-> !$past(latch_only_load_in) && !$past(erase_select_in);
   endproperty
   a_prog_mode: assert property (p_prog_mode) else $error("program in wrong mode");
   property p_protect;
      $rose(array_erase_out) |-> !$past(row_protect_in);
   endproperty
   a_protect: assert property (p_protect) else $error("erase of protected row");
   property p_row;
      $rose(write_start_out) |-> array_row_out == {flash_addr_high_out, flash_addr_low_out[7:5]}
         ##1 $stable(array_row_out) [*8];
   endproperty
   a_row: assert property (p_row) else $error("row select wrong");
   property p_op_len;
      $rose(write_start_out) |-> write_start_out [*8] ##[10:16] !write_start_out;
   endproperty
   a_op_len: assert property (p_op_len) else $error("operation length wrong");
   property p_blank;
      $fell(write_start_out) |-> ##[0:2] array_data_out == BLANK;
   endproperty
   a_blank: assert property (p_blank) else $error("latches not blank after operation");

   // ---------------------------------------------------------------
   // Completion flag
   // ---------------------------------------------------------------
   property p_flag;
      $rose(mem_op_irq_flag_out) |-> $fell(array_erase_out);
   endproperty
   a_flag: assert property (p_flag) else $error("flag set without erase end");
   property p_irq;
      mem_op_irq_out == (mem_op_irq_flag_out && $past(mem_op_irq_enable_in));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not flag and enable");
   c_prog: cover property ($rose(array_prog_out));
   c_erase: cover property ($rose(array_erase_out));
   c_irq: cover property ($rose(mem_op_irq_out));
endmodule : frsp_top_properties

// *** flash_row_self_programming_test.sv ***
// Self-checking bench of frsp_top: latch loads, row program, erase, refusals.
// Assumes the frsp package and the property checker are compiled first.
`timescale 1ns/1ps
module flash_row_self_programming_test;
   localparam int CLR = 7, AH = 6, AL = 5, WH = 4, WL = 3, KEY = 2, ST = 1, CTL = 0;
   localparam logic [447:0] BLANK = {frsp_pkg::LATCH_COUNT{frsp_pkg::BLANK_WORD}};
   typedef struct packed { logic [4:0] idx; logic [13:0] w; } frsp_row_t;
   logic clk = 1'b0, nrst = 1'b0, wen = 1'b1, ers = 1'b0, lwl = 1'b1, cfg = 1'b0;
   logic ien = 1'b1, cp = 1'b0, rp = 1'b0;
   logic [7:0] stb = 8'h00, wd = 8'h00;
   logic ws, stall, flag, irq, aprog, aers;
   logic [9:0] arow;
   logic [447:0] adata, expd;
   logic [6:0] ah;
   logic [7:0] al, wl;
   logic [5:0] wh;
   int err_count = 0, n_compared = 0;
   frsp_row_t rows [5] = '{'{5'h00, 14'h0001}, '{5'h01, 14'h2abc}, '{5'h05, 14'h1555},
                            '{5'h11, 14'h3ffe}, '{5'h1f, 14'h0000}};

   frsp_top u_frsp_top (.clk_sys_in(clk), .nrst_in(nrst), .addr_high_wr_in(stb[AH]),
      .addr_low_wr_in(stb[AL]), .word_high_wr_in(stb[WH]), .word_low_wr_in(stb[WL]),
      .unlock_key_wr_in(stb[KEY]), .start_set_in(stb[ST]), .ctrl_wr_in(stb[CTL]),
      .wdata_in(wd), .write_enable_bit_in(wen), .erase_select_in(ers),
      .latch_only_load_in(lwl), .config_space_select_in(cfg), .mem_op_irq_enable_in(ien),
      .mem_op_irq_clear_in(stb[CLR]), .code_protect_in(cp), .row_protect_in(rp),
      .flash_addr_high_out(ah), .flash_addr_low_out(al), .flash_word_high_out(wh),
      .flash_word_low_out(wl), .write_start_out(ws), .cpu_stall_out(stall),
      .mem_op_irq_flag_out(flag), .mem_op_irq_out(irq), .array_prog_out(aprog),
      .array_erase_out(aers), .array_row_out(arow), .array_data_out(adata));

   initial begin
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Drivers and compares
   // ---------------------------------------------------------------
   // Strobe lasts one full cycle; a spare cycle follows, never two writes per step
   task automatic strb(input int k, input logic [7:0] d);
      @(negedge clk);
      wd = d;
      stb = 8'h01 << k;
      @(negedge clk);
      stb = 8'h00;
   endtask : strb
   task automatic unlock();
      strb(KEY, frsp_pkg::KEY_FIRST);
      strb(KEY, frsp_pkg::KEY_SECOND);
      strb(ST, 8'h00);
   endtask : unlock
   task automatic load(input logic [4:0] i, input logic [13:0] w);
      strb(AL, {3'b101, i});
      strb(WL, w[7:0]);
      strb(WH, {2'h0, w[13:8]});
      unlock();
   endtask : load
   task automatic cmp(input string nm, input logic [447:0] e, input logic [447:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic wait_done();
      int n;
      n = 0;
      while (ws !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) cmp("op end", 0, 1);
      @(negedge clk);
   endtask : wait_done
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   initial begin
      #100us;
      err_count++;
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clk);
      cmp("reset busy", 0, {ws, stall, flag, irq, aprog, aers});
      cmp("reset latches", BLANK, adata);
      nrst = 1'b1;
      strb(AH, 8'h15);
      expd = BLANK;
      foreach (rows[r]) begin
         load(rows[r].idx, rows[r].w);
         repeat (2) @(negedge clk);
         cmp("latch load", rows[r].w, adata[14*rows[r].idx +: 14]);
         cmp("word regs", rows[r].w, {wh, wl});
         cmp("no program", 0, ws);
         expd[14*rows[r].idx +: 14] = rows[r].w;
      end
      // Final word goes into latch 30 with the commit; latch 31 keeps its earlier load
      lwl = 1'b0;
      expd[14*30 +: 14] = 14'h1234;
      load(5'h1e, 14'h1234);
      repeat (2) @(negedge clk);
      cmp("program busy", 7, {aprog, stall, ws});
      cmp("program row", {7'h15, 3'b101}, arow);
      cmp("row data", expd, adata);
      strb(AL, 8'h00);
      wait_done();
      cmp("addr held", {3'b101, 5'h1e}, al);
      cmp("after program", 0, {ws, flag});
      cmp("blank after program", BLANK, adata);
      // Unlock attempts that must come to nothing
      lwl = 1'b1;
      strb(WL, 8'h23);
      for (int c = 0; c < 6; c++) begin
         wen = (c != 2);
         cfg = (c == 3);
         cp = (c == 4);
         if (c == 1) strb(KEY, frsp_pkg::KEY_SECOND);
         strb(KEY, frsp_pkg::KEY_FIRST);
         if (c == 0) strb(CTL, 8'h00);
         if (c != 1) strb(KEY, frsp_pkg::KEY_SECOND);
         if (c == 5) strb(KEY, frsp_pkg::KEY_FIRST);
         strb(ST, 8'h00);
         repeat (3) @(negedge clk);
         cmp("refused start", 0, ws);
         cmp("refused load", BLANK, adata);
      end
      wen = 1'b1;
      cfg = 1'b0;
      cp = 1'b0;
      // Erase with a loaded latch, then interrupt handling
      unlock();
      lwl = 1'b0;
      ers = 1'b1;
      repeat (2) @(negedge clk);
      unlock();
      @(negedge clk);
      cmp("erase busy", 7, {aers, stall, ws});
      cmp("erase prog", 0, aprog);
      wait_done();
      cmp("erase flag", 3, {flag, irq});
      cmp("blank after erase", BLANK, adata);
      ien = 1'b0;
      repeat (2) @(negedge clk);
      cmp("masked irq", 2, {flag, irq});
      strb(CLR, 8'h00);
      cmp("flag cleared", 0, flag);
      // Protected row must skip the erase
      rp = 1'b1;
      unlock();
      repeat (3) @(negedge clk);
      cmp("protected erase", 0, {ws, aers, flag});
      summarize();
   end
endmodule : flash_row_self_programming_test

bind frsp_top frsp_top_properties u_frsp_top_properties (.clk_sys_in(clk_sys_in),
   .nrst_in(nrst_in), .start_set_in(start_set_in), .write_enable_bit_in(write_enable_bit_in),
   .erase_select_in(erase_select_in), .latch_only_load_in(latch_only_load_in),
   .config_space_select_in(config_space_select_in), .code_protect_in(code_protect_in),
   .mem_op_irq_enable_in(mem_op_irq_enable_in), .row_protect_in(row_protect_in),
   .flash_addr_high_out(flash_addr_high_out), .flash_addr_low_out(flash_addr_low_out),
   .write_start_out(write_start_out), .cpu_stall_out(cpu_stall_out),
   .mem_op_irq_flag_out(mem_op_irq_flag_out), .mem_op_irq_out(mem_op_irq_out),
   .array_prog_out(array_prog_out), .array_erase_out(array_erase_out),
   .array_row_out(array_row_out), .array_data_out(array_data_out));
